//--- design/tmo_match_out.sv
// match output control with apb register access
//
// Summary of operation
// - four match output state bits, each showing its output level always
// - matches on channels 0 and 1 act per fields 5:4 and 7:6
// - matches on channels 2 and 3 act per fields 9:8 and 11:10
// - action 0x1 clears the state bit on a match
// - action 0x2 sets the state bit on a match
// - action 0x3 toggles the bit; 0x0 leaves it unchanged
// - pins selected for match function are driven from the state bits
// - a pwm-selected output follows pwm logic, not the action field
`timescale 1ns/1ps
`include "tmo_regs.svh"
module tmo_match_out #(
    parameter int NUM_CH = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer core
    input wire logic [3:0] match_hit,
    input wire logic [3:0] pwm_level,
    // pin multiplexer
    output logic [3:0] match_output_pin,
    output logic [3:0] match_pin_oe
);

    generate
        if (NUM_CH != 4) begin : g_bad_param
            $error("tmo_match_out supports exactly four channels");
        end
    endgenerate

    tmo_pkg::tmo_state_type cur;
    tmo_pkg::tmo_state_type next_cur;
    tmo_pkg::tmo_core_type core;
    logic [3:0] base_level;
    logic [3:0] chan_level;
    logic access_start;
    logic access_done;
    logic hit_emc;
    logic hit_pwmsel;
    logic hit_pincfg;
    logic addr_ok;
    logic emc_wr;
    logic [31:0] read_word;

    assign core.match_hit = match_hit;
    assign core.pwm_level = pwm_level;

    // address decode
    assign hit_emc = (paddr == `TMO_EMC_ADDR);
    assign hit_pwmsel = (paddr == `TMO_PWMSEL_ADDR);
    assign hit_pincfg = (paddr == `TMO_PINCFG_ADDR);
    assign addr_ok = hit_emc | hit_pwmsel | hit_pincfg;
    assign access_start = psel & penable & ~cur.pready;
    assign access_done = psel & penable & cur.pready;
    assign emc_wr = access_done & pwrite & hit_emc;

    // read mux, reserved bits read zero
    always_comb begin
        read_word = 32'h00000000;
        if (hit_emc) begin
            read_word[`TMO_STATE_MSB:`TMO_STATE_LSB] = cur.state;
            read_word[`TMO_ACTION_MSB:`TMO_ACTION_LSB] = cur.action;
        end else if (hit_pwmsel) begin
            read_word[`TMO_SEL_MSB:`TMO_SEL_LSB] = cur.pwm_sel;
        end else if (hit_pincfg) begin
            read_word[`TMO_SEL_MSB:`TMO_SEL_LSB] = cur.pin_sel;
        end
    end

    // written level overrides the stored one
    always_comb begin
        base_level = cur.state;
        if (emc_wr && pstrb[0]) begin
            base_level = pwdata[`TMO_STATE_MSB:`TMO_STATE_LSB];
        end
    end

    // per-channel action logic
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
            tmo_channel u_ch (
                .base_level(base_level[i]),
                .action(cur.action[2*i+1:2*i]),
                .hit(core.match_hit[i]),
                .pwm_sel(cur.pwm_sel[i]),
                .pwm_level(core.pwm_level[i]),
                .next_level(chan_level[i])
            );
        end
    endgenerate

    always_comb begin
        next_cur = cur;
        next_cur.pready = access_start;
        next_cur.pslverr = 1'b0;
        if (access_start) begin
            next_cur.pslverr = ~addr_ok;
            next_cur.prdata = pwrite ? 32'h00000000 : read_word;
        end
        // register writes; reserved bits are dropped
        if (access_done && pwrite) begin
            if (hit_emc) begin
                if (pstrb[0]) begin
                    next_cur.action[3:0] = pwdata[7:4];
                end
                if (pstrb[1]) begin
                    next_cur.action[7:4] = pwdata[11:8];
                end
            end
            if (hit_pwmsel && pstrb[0]) begin
                next_cur.pwm_sel = pwdata[`TMO_SEL_MSB:`TMO_SEL_LSB];
            end
            if (hit_pincfg && pstrb[0]) begin
                next_cur.pin_sel = pwdata[`TMO_SEL_MSB:`TMO_SEL_LSB];
            end
        end
        next_cur.state = chan_level;
        next_cur.pin.level = chan_level;
        next_cur.pin.oe = next_cur.pin_sel;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur.state <= `TMO_STATE_RESET;
            cur.action <= `TMO_ACTION_RESET;
            cur.pwm_sel <= `TMO_PWMSEL_RESET;
            cur.pin_sel <= `TMO_PINCFG_RESET;
            cur.pin.level <= `TMO_STATE_RESET;
            cur.pin.oe <= `TMO_PINCFG_RESET;
            cur.pready <= 1'b0;
            cur.pslverr <= 1'b0;
            cur.prdata <= 32'h00000000;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign match_output_pin = cur.pin.level;
    assign match_pin_oe = cur.pin.oe;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_pin_tracks_state: assert property (
        match_output_pin == cur.state
    ) else $error("pin level differs from state bit");

    a_pin_oe_config: assert property (
        match_pin_oe == cur.pin_sel
    ) else $error("pin enable differs from pin config");

    a_ready_timing: assert property (
        access_start |=> pready ##1 !pready
    ) else $error("pready not one cycle after access start");

    a_unmapped_err: assert property (
        access_start && !addr_ok |=> pslverr && pready
    ) else $error("unmapped address gave no error");

    a_reserved_zero: assert property (
        access_start && !pwrite && hit_emc |=> prdata[31:12] == 20'h00000
    ) else $error("reserved bits read nonzero");

    a_state_readback: assert property (
        access_start && !pwrite && hit_emc
        |=> prdata[3:0] == $past(cur.state)
    ) else $error("read state differs from stored state");

    a_write_level: assert property (
        emc_wr && pstrb[0] && match_hit == 4'h0 && cur.pwm_sel == 4'h0
        |=> cur.state == $past(pwdata[3:0])
            && match_output_pin == $past(pwdata[3:0])
    ) else $error("written level not on state and pin");

    generate
        for (i = 0; i < NUM_CH; i = i + 1) begin : g_chk
            a_clear_action: assert property (
                match_hit[i] && !cur.pwm_sel[i]
                && cur.action[2*i+1:2*i] == 2'h1
                |=> !cur.state[i] && !match_output_pin[i]
            ) else $error("clear action did not clear bit");

            a_set_action: assert property (
                match_hit[i] && !cur.pwm_sel[i]
                && cur.action[2*i+1:2*i] == 2'h2
                |=> cur.state[i] && match_output_pin[i]
            ) else $error("set action did not set bit");

            a_toggle_action: assert property (
                match_hit[i] && !cur.pwm_sel[i] && !emc_wr
                && cur.action[2*i+1:2*i] == 2'h3
                |=> cur.state[i] != $past(cur.state[i])
            ) else $error("toggle action did not invert bit");

            a_none_action: assert property (
                match_hit[i] && !cur.pwm_sel[i] && !emc_wr
                && cur.action[2*i+1:2*i] == 2'h0
                |=> $stable(cur.state[i])
            ) else $error("do-nothing action changed bit");

            a_idle_hold: assert property (
                !match_hit[i] && !cur.pwm_sel[i] && !emc_wr
                |=> $stable(cur.state[i])
            ) else $error("state changed without match or write");

            a_pwm_override: assert property (
                cur.pwm_sel[i] |=> cur.state[i] == $past(pwm_level[i])
            ) else $error("pwm output not following pwm level");
        end
    endgenerate

    c_match_toggle: cover property (
        match_hit[0] && cur.action[1:0] == 2'h3 ##1 match_hit[0]
    );

    c_write_emc: cover property (
        emc_wr ##[1:4] match_hit[3]
    );

    c_unmapped: cover property (
        access_start && !addr_ok
    );

    c_pwm_takeover: cover property (
        $rose(cur.pwm_sel[1]) ##1 match_hit[1]
    );

endmodule

//--- design/tmo_regs.svh
// register offsets, field positions and reset values of the match outputs
`ifndef TMO_REGS_SVH
`define TMO_REGS_SVH

`define TMO_EMC_ADDR 32'h4001403C
`define TMO_PWMSEL_ADDR 32'h40014080
`define TMO_PINCFG_ADDR 32'h40014084

`define TMO_STATE_LSB 0
`define TMO_STATE_MSB 3
`define TMO_ACTION_LSB 4
`define TMO_ACTION_MSB 11
`define TMO_SEL_LSB 0
`define TMO_SEL_MSB 3

`define TMO_STATE_RESET 4'h0
`define TMO_ACTION_RESET 8'h00
`define TMO_PWMSEL_RESET 4'h0
`define TMO_PINCFG_RESET 4'h0

`endif

//--- design/tmo_pkg.sv
// types shared by the match output block
package tmo_pkg;

    typedef enum logic [1:0] {
        TMO_ACT_NONE = 2'h0,
        TMO_ACT_CLEAR = 2'h1,
        TMO_ACT_SET = 2'h2,
        TMO_ACT_TOGGLE = 2'h3
    } tmo_action_type;

    typedef struct packed {
        logic [3:0] match_hit;
        logic [3:0] pwm_level;
    } tmo_core_type;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe;
    } tmo_pin_type;

    typedef struct packed {
        logic [3:0] state;
        logic [7:0] action;
        logic [3:0] pwm_sel;
        logic [3:0] pin_sel;
        tmo_pin_type pin;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tmo_state_type;

endpackage

//--- design/tmo_channel.sv
// next level of one match output bit
`timescale 1ns/1ps
module tmo_channel (
    // stored level and write override
    input wire logic base_level,
    // match action and strobe
    input wire logic [1:0] action,
    input wire logic hit,
    // pwm takeover
    input wire logic pwm_sel,
    input wire logic pwm_level,
    // result
    output logic next_level
);
    tmo_pkg::tmo_action_type act;

    always_comb begin
        act = tmo_pkg::tmo_action_type'(action);
        next_level = base_level;
        if (pwm_sel) begin
            next_level = pwm_level;
        end else if (hit) begin
            case (act)
                tmo_pkg::TMO_ACT_CLEAR: next_level = 1'b0;
                tmo_pkg::TMO_ACT_SET: next_level = 1'b1;
                tmo_pkg::TMO_ACT_TOGGLE: next_level = ~base_level;
                default: next_level = base_level;
            endcase
        end
    end
endmodule

//--- bench/tmo_core_model.sv
// timer core stand-in: counter, comparators, pwm levels
`timescale 1ns/1ps
module tmo_core_model (
    // clock and control
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [11:0] cmp,
    input wire logic [3:0] pwm_in,
    // toward the block
    output tmo_pkg::tmo_core_type core
);
    logic [2:0] count;
    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            count <= 3'h0;
        end else begin
            count <= count + 3'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            core.match_hit[i] = run && (count == cmp[3*i +: 3]);
        end
        core.pwm_level = pwm_in;
    end
endmodule

//--- bench/test_timer_match_output_control.sv
// self-checking bench of the match output block
`timescale 1ns/1ps
`include "tmo_regs.svh"
module test_timer_match_output_control;
    logic sys_clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic run = 0;
    logic [11:0] cmp = 12'h0;
    logic [3:0] pwm_in = 4'h0;
    tmo_pkg::tmo_core_type core;
    logic [3:0] pin;
    logic [3:0] oe;
    logic [11:0] emc;
    logic [3:0] sel;
    logic [3:0] cfg;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int checks_done = 0;

    tmo_match_out u_dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .match_hit(core.match_hit), .pwm_level(core.pwm_level),
        .match_output_pin(pin), .match_pin_oe(oe)
    );
    tmo_core_model u_core (
        .sys_clk(sys_clk), .rst(rst), .run(run), .cmp(cmp),
        .pwm_in(pwm_in), .core(core)
    );

    function automatic logic act(logic [1:0] a, logic s);
        case (a)
            2'h1: return 1'b0;
            2'h2: return 1'b1;
            2'h3: return ~s;
            default: return s;
        endcase
    endfunction

    // reference registers
    always @(posedge sys_clk) begin
        logic [11:0] n;
        logic w;
        n = emc;
        w = psel && penable && pready === 1'b1 && pwrite;
        if (w && paddr == `TMO_EMC_ADDR) begin
            if (pstrb[0]) n[7:0] = pwdata[7:0];
            if (pstrb[1]) n[11:8] = pwdata[11:8];
        end
        for (int i = 0; i < 4; i++) begin
            if (core.match_hit[i]) n[i] = act(emc[4+2*i +: 2], n[i]);
            if (sel[i]) n[i] = core.pwm_level[i];
        end
        if (w && paddr == `TMO_PWMSEL_ADDR && pstrb[0]) sel <= pwdata[3:0];
        if (w && paddr == `TMO_PINCFG_ADDR && pstrb[0]) cfg <= pwdata[3:0];
        if (rst) begin
            sel <= 4'h0;
            cfg <= 4'h0;
        end
        emc <= rst ? 12'h0 : n;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(negedge sys_clk) begin
        if (!rst) begin
            chk(32'(pin), 32'(emc[3:0]));
            chk(32'(oe), 32'(cfg));
        end
    end

    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic e);
        apb(1'b0, a, 32'h0, 4'h0);
        case (a)
            `TMO_EMC_ADDR: chk(rd, 32'(emc));
            `TMO_PWMSEL_ADDR: chk(rd, 32'(sel));
            `TMO_PINCFG_ADDR: chk(rd, 32'(cfg));
            default: chk(rd, 32'h0);
        endcase
        chk(32'(err), 32'(e));
    endtask

    task automatic test_done;
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #(40 * 20000);
        n_errors++;
        test_done;
    end
    initial begin
        logic [31:0] v;
        void'($urandom(53));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(`TMO_EMC_ADDR, 1'b0);
        rdchk(`TMO_PINCFG_ADDR, 1'b0);
        rdchk(32'h40014040, 1'b1);
        for (int t = 0; t < 24; t++) begin
            v = {20'h0, 12'($urandom)};
            if (t < 4) v[11:4] = {4{2'(t)}};
            apb(1'b1, `TMO_EMC_ADDR, v, t < 8 ? 4'hF : 4'($urandom));
            apb(1'b1, `TMO_PWMSEL_ADDR, t < 8 ? 32'h0 : 32'($urandom % 16),
                4'hF);
            apb(1'b1, `TMO_PINCFG_ADDR, 32'($urandom % 16), 4'hF);
            rdchk(`TMO_EMC_ADDR, 1'b0);
            cmp <= 12'($urandom);
            run <= 1'b1;
            repeat (20) begin
                @(posedge sys_clk);
                pwm_in <= 4'($urandom);
            end
            run <= 1'b0;
            rdchk(`TMO_EMC_ADDR, 1'b0);
            rdchk(`TMO_PWMSEL_ADDR, 1'b0);
        end
        test_done;
    end
endmodule
